// [design/swd_decoder.v]
// scan window descriptor decoder with apb register access
//
// Contract
// - origin x in 1/1200 inch from right
// - origin y from top, origins default zero
// - width default 10200, aligned to 8*xres
// - length default 13200 units
// - brightness zero means 128, else relative
// - threshold zero means 128, else relative
// - contrast zero means 128, grayscale only
// - composition 00,02,03,05 decoded; 00 default
// - accept depths 4,8,3,24
// - depth field applies only in grayscale
// - padding must be 03, truncate
// - compression must be zero, uncompressed
// - top/bottom refs set converter range ends
// - any zero ref disables both refs
// - nonzero ref used directly, unscaled
// - xres 72..300, zero means 72
`include "swd_regs.vh"
module swd_decoder
(
   // clock and reset
   input  wire        CLOCK,
   input  wire        RST_B,
   // apb slave
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [11:0] PADDR,
   input  wire [31:0] PWDATA,
   output reg  [31:0] PRDATA,
   output reg         PREADY,
   output reg         PSLVERR,
   // decoded window to the scan engine
   output reg         WIN_VALID,
   output reg         WIN_PARAM_ERR,
   output reg  [31:0] WIN_ORG_X,
   output reg  [31:0] WIN_ORG_Y,
   output reg  [31:0] WIN_WIDTH,
   output reg  [31:0] WIN_LENGTH,
   output reg  [15:0] WIN_XRES,
   output reg  [7:0]  WIN_BRIGHT,
   output reg  [7:0]  WIN_THRESH,
   output reg  [7:0]  WIN_CONTRAST,
   output reg         WIN_CONTRAST_EN,
   output reg  [7:0]  WIN_COMP,
   output reg  [7:0]  WIN_BPP,
   output reg         WIN_REF_EN,
   output reg  [7:0]  WIN_REF_TOP,
   output reg  [7:0]  WIN_REF_BOT
);

   // raw descriptor fields as written by software
   // geometry in 1/1200 inch, resolution in dpi
   reg [15:0] xres_reg;
   reg [31:0] orgx_reg;
   reg [31:0] orgy_reg;
   reg [31:0] width_reg;
   reg [31:0] length_reg;
   // level, format and reference codes
   reg [7:0]  bright_reg;
   reg [7:0]  thresh_reg;
   reg [7:0]  contr_reg;
   reg [7:0]  comp_reg;
   reg [7:0]  bpp_reg;
   reg [7:0]  pad_reg;
   reg [7:0]  cmp_reg;
   reg [7:0]  rtop_reg;
   reg [7:0]  rbot_reg;

   // zero code selects the mid setting
   function [7:0] lvl;
      input [7:0] code;
      begin
         // shared by brightness, threshold and contrast
         lvl = (code == 8'h00) ? `SWD_DEF_LEVEL : code;
      end
   endfunction

   // alignment: value must be a multiple of 8*xres
   function aligned;
      input [31:0] val;
      input [15:0] res;
      // 64 bits so the largest shifted divisor never wraps and
      // a wrapped divisor can never be subtracted by mistake
      reg   [63:0] step;
      reg   [63:0] acc;
      integer i;
      begin
         step = {45'h0, res, 3'b000};
         acc = {32'h0, val};
         // restoring remainder, bounded loop keeps it synthesizable
         for (i = 31; i >= 0; i = i - 1)
         begin
            if (acc >= (step << i))
               acc = acc - (step << i);
         end
         aligned = (acc == 64'h0);
      end
   endfunction

   // combinational decode of the held descriptor
   reg [15:0] xres_eff;
   reg [31:0] width_eff;
   reg [31:0] length_eff;
   reg [7:0]  bpp_eff;
   reg        comp_ok;
   reg        bpp_ok;
   reg        res_ok;
   reg        perr;
   reg        ref_en;
   always @*
   begin
      // zero resolution selects the lowest supported one
      xres_eff = (xres_reg == 16'h0000) ? `SWD_DEF_XRES : xres_reg;
      res_ok = (xres_eff >= `SWD_DEF_XRES) && (xres_eff <= `SWD_MAX_XRES);
      width_eff = (width_reg == 32'h0) ? `SWD_DEF_WIDTH : width_reg;
      length_eff = (length_reg == 32'h0) ? `SWD_DEF_LENGTH : length_reg;
      comp_ok = (comp_reg == `SWD_COMP_LINEART) || (comp_reg == `SWD_COMP_GRAY)
         || (comp_reg == `SWD_COMP_BICOLOR) || (comp_reg == `SWD_COMP_FULLCLR);
      // depth only read in grayscale; others take the mode's fixed depth
      bpp_ok = 1'b1;
      case (comp_reg)
         `SWD_COMP_GRAY:
         begin
            bpp_eff = bpp_reg;
            bpp_ok = (bpp_reg == `SWD_BPP_GRAY4) || (bpp_reg == `SWD_BPP_GRAY8);
         end
         `SWD_COMP_BICOLOR: bpp_eff = `SWD_BPP_BICLR;
         `SWD_COMP_FULLCLR: bpp_eff = `SWD_BPP_FULL;
         default:           bpp_eff = `SWD_BPP_LINE;
      endcase
      // one bad field rejects the whole descriptor
      perr = !comp_ok || !bpp_ok || !res_ok
         || (pad_reg != `SWD_PAD_TRUNC)
         || (cmp_reg != `SWD_CMP_NONE)
         || !aligned(orgx_reg, xres_eff)
         || !aligned(width_eff, xres_eff);
      // either level at zero falls back to brightness and contrast
      ref_en = (rtop_reg != 8'h00) && (rbot_reg != 8'h00);
   end

   // apb decode; zero wait states
   // writes commit in setup, so an apply sees fields written just before
   wire apb_setup = PSEL && !PENABLE;
   wire apb_wr    = apb_setup && PWRITE;
   wire apply     = apb_wr && (PADDR == `SWD_CTRL_OFF) && PWDATA[`SWD_CTRL_APPLY];

   // address check used for the error answer
   function known;
      input [11:0] a;
      begin
         // holes above the last word and unaligned bytes both answer with error
         known = (a[1:0] == 2'b00) && (a <= `SWD_OUT_MODE_OFF);
      end
   endfunction

   // register writes, committed in the setup cycle of each transfer
   always @(posedge CLOCK)
   begin
      if (!RST_B)
      begin
         xres_reg <= 16'h0000;
         orgx_reg <= 32'h0;
         orgy_reg <= 32'h0;
         width_reg <= 32'h0;
         length_reg <= 32'h0;
         bright_reg <= 8'h00;
         thresh_reg <= 8'h00;
         contr_reg <= 8'h00;
         comp_reg <= 8'h00;
         bpp_reg <= 8'h00;
         // padding and compression start at their only legal codes
         pad_reg <= `SWD_PAD_TRUNC;
         cmp_reg <= `SWD_CMP_NONE;
         rtop_reg <= 8'h00;
         rbot_reg <= 8'h00;
      end
      else if (apb_wr)
      begin
         case (PADDR)
            `SWD_XRES_OFF:   xres_reg <= PWDATA[15:0];
            `SWD_ORGX_OFF:   orgx_reg <= PWDATA;
            `SWD_ORGY_OFF:   orgy_reg <= PWDATA;
            `SWD_WIDTH_OFF:  width_reg <= PWDATA;
            `SWD_LENGTH_OFF: length_reg <= PWDATA;
            `SWD_LEVELS_OFF:
            begin
               bright_reg <= PWDATA[7:0];
               thresh_reg <= PWDATA[15:8];
               contr_reg <= PWDATA[23:16];
            end
            `SWD_FORMAT_OFF:
            begin
               comp_reg <= PWDATA[7:0];
               bpp_reg <= PWDATA[15:8];
               pad_reg <= PWDATA[23:16];
               cmp_reg <= PWDATA[31:24];
            end
            `SWD_REFS_OFF:
            begin
               rtop_reg <= PWDATA[7:0];
               rbot_reg <= PWDATA[15:8];
            end
            // status and decoded words are read-only, writes there drop
            default: ;
         endcase
      end
   end

   // apply: latch decoded window or flag error, previous window kept on error
   always @(posedge CLOCK)
   begin
      if (!RST_B)
      begin
         // power-up window: defaults everywhere, nothing valid yet
         WIN_VALID <= 1'b0;
         WIN_PARAM_ERR <= 1'b0;
         WIN_ORG_X <= `SWD_DEF_ORG;
         WIN_ORG_Y <= `SWD_DEF_ORG;
         WIN_WIDTH <= `SWD_DEF_WIDTH;
         WIN_LENGTH <= `SWD_DEF_LENGTH;
         WIN_XRES <= `SWD_DEF_XRES;
         WIN_BRIGHT <= `SWD_DEF_LEVEL;
         WIN_THRESH <= `SWD_DEF_LEVEL;
         WIN_CONTRAST <= `SWD_DEF_LEVEL;
         WIN_CONTRAST_EN <= 1'b0;
         WIN_COMP <= `SWD_COMP_LINEART;
         WIN_BPP <= `SWD_BPP_LINE;
         WIN_REF_EN <= 1'b0;
         WIN_REF_TOP <= 8'h00;
         WIN_REF_BOT <= 8'h00;
      end
      else if (apply)
      begin
         WIN_PARAM_ERR <= perr;
         WIN_VALID <= !perr;
         // a rejected descriptor leaves the last good window with the engine
         if (!perr)
         begin
            WIN_ORG_X <= orgx_reg;
            WIN_ORG_Y <= orgy_reg;
            WIN_WIDTH <= width_eff;
            WIN_LENGTH <= length_eff;
            WIN_XRES <= xres_eff;
            WIN_BRIGHT <= lvl(bright_reg);
            WIN_THRESH <= lvl(thresh_reg);
            WIN_CONTRAST <= lvl(contr_reg);
            // contrast only reaches the converter in grayscale
            WIN_CONTRAST_EN <= (comp_reg == `SWD_COMP_GRAY);
            WIN_COMP <= comp_reg;
            WIN_BPP <= bpp_eff;
            WIN_REF_EN <= ref_en;
            // refs passed unscaled; zeroed when disabled
            WIN_REF_TOP <= ref_en ? rtop_reg : 8'h00;
            WIN_REF_BOT <= ref_en ? rbot_reg : 8'h00;
         end
      end
   end

   // read mux and ready, registered so the answer is in the access cycle
   always @(posedge CLOCK)
   begin
      if (!RST_B)
      begin
         PRDATA <= 32'h0;
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end
      else
      begin
         // zero-wait slave: ready follows every setup by one cycle
         PREADY <= apb_setup;
         PSLVERR <= apb_setup && !known(PADDR);
         PRDATA <= 32'h0;
         if (apb_setup && !PWRITE)
         begin
            // ctrl reads zero: apply is a strobe, not state
            case (PADDR)
               `SWD_XRES_OFF:   PRDATA <= {16'h0000, xres_reg};
               `SWD_ORGX_OFF:   PRDATA <= orgx_reg;
               `SWD_ORGY_OFF:   PRDATA <= orgy_reg;
               `SWD_WIDTH_OFF:  PRDATA <= width_reg;
               `SWD_LENGTH_OFF: PRDATA <= length_reg;
               `SWD_LEVELS_OFF: PRDATA <= {8'h00, contr_reg, thresh_reg, bright_reg};
               `SWD_FORMAT_OFF: PRDATA <= {cmp_reg, pad_reg, bpp_reg, comp_reg};
               `SWD_REFS_OFF:   PRDATA <= {16'h0000, rbot_reg, rtop_reg};
               // status and decoded window, straight from the output flops
               `SWD_STATUS_OFF: PRDATA <= {28'h0, WIN_CONTRAST_EN, WIN_REF_EN,
                                           WIN_PARAM_ERR, WIN_VALID};
               `SWD_OUT_GEOM_OFF: PRDATA <= WIN_WIDTH;
               `SWD_OUT_LEN_OFF:  PRDATA <= WIN_LENGTH;
               `SWD_OUT_LVL_OFF:  PRDATA <= {8'h00, WIN_CONTRAST, WIN_THRESH, WIN_BRIGHT};
               `SWD_OUT_MODE_OFF: PRDATA <= {16'h0000, WIN_BPP, WIN_COMP};
               default: PRDATA <= 32'h0;
            endcase
         end
      end
   end

endmodule

// [design/swd_regs.vh]
// register offsets, field defaults and decode constants for the window descriptor decoder
`ifndef SWD_REGS_VH
`define SWD_REGS_VH
// apb byte offsets
`define SWD_CTRL_OFF    12'h000
`define SWD_XRES_OFF    12'h004
`define SWD_ORGX_OFF    12'h008
`define SWD_ORGY_OFF    12'h00c
`define SWD_WIDTH_OFF   12'h010
`define SWD_LENGTH_OFF  12'h014
`define SWD_LEVELS_OFF  12'h018
`define SWD_FORMAT_OFF  12'h01c
`define SWD_REFS_OFF    12'h020
`define SWD_STATUS_OFF  12'h024
`define SWD_OUT_GEOM_OFF 12'h028
`define SWD_OUT_LEN_OFF 12'h02c
`define SWD_OUT_LVL_OFF 12'h030
`define SWD_OUT_MODE_OFF 12'h034
// control bit
`define SWD_CTRL_APPLY  0
// defaults
`define SWD_DEF_ORG     32'h0000_0000
`define SWD_DEF_WIDTH   32'h0000_27d8
`define SWD_DEF_LENGTH  32'h0000_3390
`define SWD_DEF_LEVEL   8'h80
`define SWD_DEF_XRES    16'h0048
`define SWD_MAX_XRES    16'h012c
// composition codes
`define SWD_COMP_LINEART 8'h00
`define SWD_COMP_GRAY    8'h02
`define SWD_COMP_BICOLOR 8'h03
`define SWD_COMP_FULLCLR 8'h05
// pixel depths
`define SWD_BPP_GRAY4   8'h04
`define SWD_BPP_GRAY8   8'h08
`define SWD_BPP_BICLR   8'h03
`define SWD_BPP_FULL    8'h18
`define SWD_BPP_LINE    8'h01
// padding and compression
`define SWD_PAD_TRUNC   8'h03
`define SWD_CMP_NONE    8'h00
// status bits
`define SWD_ST_VALID    0
`define SWD_ST_PERR     1
`define SWD_ST_REFEN    2
`define SWD_ST_CONTRAST 3
`endif

// [tb/swd_props.sv]
// concurrent checks on the descriptor decoder ports
module swd_props
(
   // clock, reset and apb
   input logic        CLOCK,
   input logic        RST_B,
   input logic        PSEL,
   input logic        PENABLE,
   input logic        PWRITE,
   input logic [11:0] PADDR,
   input logic [31:0] PWDATA,
   input logic        PREADY,
   input logic        PSLVERR,
   // decoded window
   input logic        WIN_VALID,
   input logic        WIN_PARAM_ERR,
   input logic [31:0] WIN_WIDTH,
   input logic [15:0] WIN_XRES,
   input logic [7:0]  WIN_BRIGHT,
   input logic        WIN_CONTRAST_EN,
   input logic [7:0]  WIN_COMP,
   input logic [7:0]  WIN_BPP,
   input logic        WIN_REF_EN,
   input logic [7:0]  WIN_REF_TOP,
   input logic [7:0]  WIN_REF_BOT
);
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RST_B);
   // apply is a ctrl write seen in its setup cycle
   wire setup = PSEL && !PENABLE;
   wire apply = setup && PWRITE && PADDR == 12'h000 && PWDATA[0];
   a_ready_setup: assert property (setup |=> PREADY && PSEL && PENABLE)
      else $error("no ready after setup");
   a_ready_once: assert property (PREADY |=> !PREADY)
      else $error("ready longer than one cycle");
   a_err_ready: assert property (PSLVERR |-> PREADY)
      else $error("slave error without ready");
   a_apply_verdict: assert property (apply |=> WIN_VALID != WIN_PARAM_ERR)
      else $error("apply gave no single verdict");
   a_hold_window: assert property (!apply |=> $stable(WIN_WIDTH) && $stable(WIN_VALID))
      else $error("window changed without apply");
   a_width_aligned: assert property (WIN_VALID |-> WIN_WIDTH % {WIN_XRES, 3'b000} == 0)
      else $error("valid window with misaligned width");
   a_bright_set: assert property (WIN_BRIGHT != 8'h00)
      else $error("brightness left at zero");
   a_ref_pair: assert property (WIN_REF_EN == (WIN_REF_TOP != 0 && WIN_REF_BOT != 0))
      else $error("reference enable disagrees with levels");
   a_gray_contrast: assert property (WIN_CONTRAST_EN == (WIN_COMP == 8'h02))
      else $error("contrast enable outside grayscale");
   a_depth_mode: assert property (WIN_COMP != 8'h02 |->
      WIN_BPP == (WIN_COMP == 8'h00 ? 8'h01 : WIN_COMP == 8'h03 ? 8'h03 : 8'h18))
      else $error("depth not taken from mode");
   a_xres_range: assert property (WIN_XRES >= 16'h0048 && WIN_XRES <= 16'h012c)
      else $error("resolution out of range");
   // main scenarios
   c_apply_ok: cover property (apply ##1 WIN_VALID);
   c_apply_bad: cover property (apply ##1 WIN_PARAM_ERR);
   c_slave_err: cover property (PSLVERR);
   c_refs_on: cover property (WIN_REF_EN);
endmodule

bind swd_decoder swd_props swd_props_inst (.CLOCK(CLOCK), .RST_B(RST_B), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .WIN_VALID(WIN_VALID), .WIN_PARAM_ERR(WIN_PARAM_ERR),
   .WIN_WIDTH(WIN_WIDTH), .WIN_XRES(WIN_XRES), .WIN_BRIGHT(WIN_BRIGHT),
   .WIN_CONTRAST_EN(WIN_CONTRAST_EN), .WIN_COMP(WIN_COMP), .WIN_BPP(WIN_BPP),
   .WIN_REF_EN(WIN_REF_EN), .WIN_REF_TOP(WIN_REF_TOP), .WIN_REF_BOT(WIN_REF_BOT));

// [tb/swd_host.sv]
// host model: apb master that loads descriptor fields
module swd_host
(
   // clock
   input  logic        clk,
   // apb request
   output logic        psel = 1'b0,
   output logic        penable = 1'b0,
   output logic        pwrite = 1'b0,
   output logic [11:0] paddr = 12'h000,
   output logic [31:0] pwdata = 32'h0000_0000,
   // apb answer
   input  logic [31:0] prdata,
   input  logic        pready,
   input  logic        pslverr
);
   timeunit 1ns;
   timeprecision 1ns;
   // one transfer, held until ready is sampled high; only the bench watchdog ends a wait
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines stop showing the old value
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule

// [tb/testbench.sv]
// self-checking bench for the window descriptor decoder
`include "swd_regs.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock = 1'b0;
   logic        rst_b = 1'b0;
   wire         psel, penable, pwrite, pready, pslverr, win_valid, win_err, con_en, ref_en;
   wire  [11:0] paddr;
   wire  [31:0] pwdata, prdata, org_x, org_y, width, length;
   wire  [15:0] xres;
   wire  [7:0]  bright, thresh, contrast, comp, bpp, ref_top, ref_bot;
   logic [31:0] rdv;
   logic        rerr;
   int          failures = 0;
   int          n_compared = 0;
   logic [7:0]  cm [4] = '{8'h00, 8'h02, 8'h03, 8'h05};
   logic [7:0]  eb [4] = '{8'h01, 8'h04, 8'h03, 8'h18};
   logic [11:0] bad_a [7] = '{`SWD_FORMAT_OFF, `SWD_FORMAT_OFF, `SWD_FORMAT_OFF,
      `SWD_FORMAT_OFF, `SWD_XRES_OFF, `SWD_ORGX_OFF, `SWD_WIDTH_OFF};
   logic [31:0] bad_v [7] = '{32'h0003_0801, 32'h0003_0602, 32'h0000_0802,
      32'h0103_0802, 32'h12d, 32'h4b1, 32'h259};
   swd_decoder swd_decoder_inst (.CLOCK(clock), .RST_B(rst_b), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .WIN_VALID(win_valid), .WIN_PARAM_ERR(win_err),
      .WIN_ORG_X(org_x), .WIN_ORG_Y(org_y), .WIN_WIDTH(width), .WIN_LENGTH(length),
      .WIN_XRES(xres), .WIN_BRIGHT(bright), .WIN_THRESH(thresh), .WIN_CONTRAST(contrast),
      .WIN_CONTRAST_EN(con_en), .WIN_COMP(comp), .WIN_BPP(bpp), .WIN_REF_EN(ref_en),
      .WIN_REF_TOP(ref_top), .WIN_REF_BOT(ref_bot));
   swd_host swd_host_inst (.clk(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // clock and hang guard
   initial
   begin
      forever #10 clock = ~clock;
   end
   initial
   begin
      #100us;
      failures++;
      tally_and_finish();
   end
   task automatic check(input string what, input logic [95:0] seen, input logic [95:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      swd_host_inst.xfer(1'b1, a, d, rdv, rerr);
   endtask
   task automatic rd(input logic [11:0] a);
      swd_host_inst.xfer(1'b0, a, 32'h0, rdv, rerr);
   endtask
   task automatic apply;
      wr(`SWD_CTRL_OFF, 32'h1);
   endtask
   // aligned gray descriptor: 75 dpi makes the default width fit byte edges
   task automatic good;
      wr(`SWD_XRES_OFF, 32'h4b);
      wr(`SWD_ORGX_OFF, 32'h4b0);
      wr(`SWD_ORGY_OFF, 32'h7);
      wr(`SWD_WIDTH_OFF, 32'h0);
      wr(`SWD_LENGTH_OFF, 32'h0);
      wr(`SWD_LEVELS_OFF, 32'h0);
      wr(`SWD_FORMAT_OFF, 32'h0003_0802);
      wr(`SWD_REFS_OFF, 32'h0);
   endtask
   initial
   begin
      repeat (16) @(posedge clock);
      check("reset", {width, length}, {32'h27d8, 32'h3390});
      check("reset", {xres, bright, win_valid}, {16'h0048, 8'h80, 1'b0});
      rst_b <= 1'b1;
      $display("test reset done");
      good();
      apply();
      check("orgs", {win_valid, org_x, org_y}, {1'b1, 32'h4b0, 32'h7});
      check("size", {width, length}, {32'h27d8, 32'h3390});
      check("levels", {bright, thresh, contrast}, 24'h808080);
      check("refs", {ref_en, ref_top, ref_bot}, 17'h0);
      rd(`SWD_STATUS_OFF);
      check("status", rdv, 32'h9);
      $display("test defaults done");
      wr(`SWD_LEVELS_OFF, 32'h0040_ff01);
      wr(`SWD_REFS_OFF, 32'h0000_0310);
      for (int i = 0; i < 4; i++)
      begin
         wr(`SWD_FORMAT_OFF, {8'h00, 8'h03, 8'h04, cm[i]});
         apply();
         check("mode", {comp, bpp, con_en}, {cm[i], eb[i], i == 1});
         check("levels", {bright, thresh, contrast}, 24'h01ff40);
         check("refs", {ref_en, ref_top, ref_bot}, 17'h11003);
      end
      rd(`SWD_OUT_LVL_OFF);
      check("out levels", rdv, 32'h0040_ff01);
      rd(`SWD_OUT_MODE_OFF);
      check("out mode", rdv, 32'h0000_1805);
      rd(`SWD_STATUS_OFF);
      check("status", rdv, 32'h5);
      wr(`SWD_REFS_OFF, 32'h0000_0010);
      wr(`SWD_XRES_OFF, 32'h0);
      wr(`SWD_ORGX_OFF, 32'h0);
      wr(`SWD_WIDTH_OFF, 32'h2d00);
      apply();
      check("refs", {ref_en, ref_top, ref_bot}, 17'h0);
      check("xres", {win_valid, xres, width}, {1'b1, 16'h0048, 32'h2d00});
      $display("test modes done");
      for (int i = 0; i < 7; i++)
      begin
         good();
         apply();
         wr(bad_a[i], bad_v[i]);
         apply();
         check("reject", {win_valid, win_err, comp, org_x}, {2'b01, 8'h02, 32'h4b0});
      end
      rd(12'h040);
      check("unmapped", {rerr, rdv}, {1'b1, 32'h0});
      rd(12'h003);
      check("misaligned", rerr, 1'b1);
      wr(12'h040, 32'hffff_ffff);
      check("unmapped write", rerr, 1'b1);
      rd(`SWD_STATUS_OFF);
      check("status", rdv[1:0], 2'b10);
      $display("test errors done");
      tally_and_finish();
   end
endmodule
